// File: design/buck_cfg_pkg.sv
// package: register map, field layout, reset values and encodings of the buck channel bank
`default_nettype none
package buck_cfg_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] run_voltage_setpoint_addr     = 8'h43;
  localparam logic [7:0] standby_voltage_setpoint_addr = 8'h44;
  localparam logic [7:0] sleep_voltage_setpoint_addr   = 8'h45;
  localparam logic [7:0] switching_mode_control_addr   = 8'h46;
  localparam logic [7:0] regulator_configuration_addr  = 8'h47;

  // ****************************************
  // field positions
  // ****************************************
  localparam int voltage_code_lsb     = 0;
  localparam int voltage_code_msb     = 5;
  localparam int range_bit            = 6;
  localparam int mode_field_lsb       = 0;
  localparam int mode_field_msb       = 3;
  localparam int sleep_state_bit      = 5;
  localparam int current_limit_bit    = 0;
  localparam int freq_field_lsb       = 2;
  localparam int freq_field_msb       = 3;
  localparam int phase_field_lsb      = 4;
  localparam int phase_field_msb      = 5;
  localparam int ramp_field_lsb       = 6;
  localparam int ramp_field_msb       = 7;

  // ****************************************
  // reset values and the default read value
  // ****************************************
  localparam logic [5:0] voltage_code_reset  = 6'h00;
  localparam logic [3:0] mode_field_reset    = 4'h8;
  localparam logic [7:0] conf_reset          = 8'h00;
  localparam logic [7:0] read_zero           = 8'h00;

  // ****************************************
  // frequency encodings, nominal switching rate in kHz
  // ****************************************
  localparam logic [1:0] freq_sel_1mhz = 2'h0;
  localparam logic [1:0] freq_sel_2mhz = 2'h1;
  localparam logic [1:0] freq_sel_4mhz = 2'h2;
  localparam logic [12:0] freq_1mhz_khz = 13'h03E8;
  localparam logic [12:0] freq_2mhz_khz = 13'h07D0;
  localparam logic [12:0] freq_4mhz_khz = 13'h0FA0;

  typedef enum logic [1:0] {
    pstate_normal,
    pstate_standby,
    pstate_sleep
  } power_state_e;

  // drive bundle handed to the regulator analog section
  typedef struct packed {
    logic [5:0]  voltage_code;
    logic        range_high;
    logic        channel_on;
    logic        pfm_forced;
    logic [3:0]  switching_mode;
    logic        low_current_limit;
    logic [1:0]  freq_select;
    logic [12:0] freq_khz;
    logic [1:0]  phase_select;
    logic [1:0]  ramp_select;
  } regulator_drive_s;

endpackage : buck_cfg_pkg
`default_nettype wire

// File: design/buck_channel_config_regs.sv
// buck channel configuration register bank with set point selection
//
// The implementer's own choice: strobed register access.
`default_nettype none
module buck_channel_config_regs
  import buck_cfg_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             cfg_load,
  input  wire logic             cfg_range,
  input  wire power_state_e     power_state,
  output regulator_drive_s      drive
);

  // ****************************************
  // storage
  // ****************************************
  logic [5:0] run_code_r,   run_code_nxt;
  logic [5:0] stby_code_r,  stby_code_nxt;
  logic [5:0] sleep_code_r, sleep_code_nxt;
  logic       range_r,      range_nxt;
  logic [3:0] mode_r,       mode_nxt;
  logic       sleep_sel_r,  sleep_sel_nxt;
  logic [7:0] conf_r,       conf_nxt;
  logic [7:0] rdata_r,      rdata_nxt;
  regulator_drive_s drive_r, drive_nxt;

  // ****************************************
  // register writes
  // ****************************************
  always_comb begin
    run_code_nxt   = run_code_r;
    stby_code_nxt  = stby_code_r;
    sleep_code_nxt = sleep_code_r;
    range_nxt      = range_r;
    mode_nxt       = mode_r;
    sleep_sel_nxt  = sleep_sel_r;
    conf_nxt       = conf_r;
    // range comes only from the configuration loader, never from the bus
    if (cfg_load) begin
      range_nxt = cfg_range;
    end
    if (reg_wr) begin
      case (reg_addr)
        run_voltage_setpoint_addr: begin
          run_code_nxt = reg_wdata[voltage_code_msb:voltage_code_lsb];
        end
        standby_voltage_setpoint_addr: begin
          stby_code_nxt = reg_wdata[voltage_code_msb:voltage_code_lsb];
        end
        sleep_voltage_setpoint_addr: begin
          sleep_code_nxt = reg_wdata[voltage_code_msb:voltage_code_lsb];
        end
        switching_mode_control_addr: begin
          mode_nxt      = reg_wdata[mode_field_msb:mode_field_lsb];
          sleep_sel_nxt = reg_wdata[sleep_state_bit];
        end
        regulator_configuration_addr: begin
          // bit 1 is stored as writable but steers nothing
          conf_nxt = reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // read path, data one cycle after the strobe
  // ****************************************
  always_comb begin
    rdata_nxt = read_zero;
    if (reg_rd) begin
      case (reg_addr)
        run_voltage_setpoint_addr: begin
          rdata_nxt[voltage_code_msb:voltage_code_lsb] = run_code_r;
          rdata_nxt[range_bit] = range_r;
        end
        standby_voltage_setpoint_addr: begin
          rdata_nxt[voltage_code_msb:voltage_code_lsb] = stby_code_r;
          rdata_nxt[range_bit] = range_r;
        end
        sleep_voltage_setpoint_addr: begin
          rdata_nxt[voltage_code_msb:voltage_code_lsb] = sleep_code_r;
          rdata_nxt[range_bit] = range_r;
        end
        switching_mode_control_addr: begin
          rdata_nxt[mode_field_msb:mode_field_lsb] = mode_r;
          rdata_nxt[sleep_state_bit] = sleep_sel_r;
        end
        regulator_configuration_addr: begin
          rdata_nxt = conf_r;
        end
        default: begin
          rdata_nxt = read_zero;
        end
      endcase
    end
  end

  // ****************************************
  // regulator drive
  // ****************************************
  always_comb begin
    drive_nxt                   = '0;
    drive_nxt.range_high        = range_r;
    drive_nxt.switching_mode    = mode_r;
    drive_nxt.channel_on        = 1'b1;
    drive_nxt.low_current_limit = conf_r[current_limit_bit];
    drive_nxt.freq_select       = conf_r[freq_field_msb:freq_field_lsb];
    drive_nxt.phase_select      = conf_r[phase_field_msb:phase_field_lsb];
    drive_nxt.ramp_select       = conf_r[ramp_field_msb:ramp_field_lsb];
    case (conf_r[freq_field_msb:freq_field_lsb])
      freq_sel_1mhz: drive_nxt.freq_khz = freq_1mhz_khz;
      freq_sel_2mhz: drive_nxt.freq_khz = freq_2mhz_khz;
      freq_sel_4mhz: drive_nxt.freq_khz = freq_4mhz_khz;
      // code 11 has no documented rate; hold the slowest as the safe choice
      default:       drive_nxt.freq_khz = freq_1mhz_khz;
    endcase
    case (power_state)
      pstate_normal: begin
        drive_nxt.voltage_code = run_code_r;
      end
      pstate_standby: begin
        drive_nxt.voltage_code = stby_code_r;
      end
      pstate_sleep: begin
        drive_nxt.voltage_code = sleep_code_r;
        drive_nxt.channel_on   = sleep_sel_r;
        drive_nxt.pfm_forced   = sleep_sel_r;
      end
      default: begin
        // undefined state code: fall back to the normal set point
        drive_nxt.voltage_code = run_code_r;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      run_code_r   <= voltage_code_reset;
      stby_code_r  <= voltage_code_reset;
      sleep_code_r <= voltage_code_reset;
      range_r      <= 1'b0;
      mode_r       <= mode_field_reset;
      sleep_sel_r  <= 1'b0;
      conf_r       <= conf_reset;
      rdata_r      <= read_zero;
      drive_r      <= '0;
    end else begin
      run_code_r   <= run_code_nxt;
      stby_code_r  <= stby_code_nxt;
      sleep_code_r <= sleep_code_nxt;
      range_r      <= range_nxt;
      mode_r       <= mode_nxt;
      sleep_sel_r  <= sleep_sel_nxt;
      conf_r       <= conf_nxt;
      rdata_r      <= rdata_nxt;
      drive_r      <= drive_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign drive     = drive_r;

endmodule : buck_channel_config_regs
`default_nettype wire

// File: sim/buck_cfg_monitor.sv
// checker: port assertions for the buck channel register bank
`default_nettype none
module buck_cfg_monitor
  import buck_cfg_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire logic [7:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic             cfg_load,
  input wire logic             cfg_range,
  input wire power_state_e     power_state,
  input wire regulator_drive_s drive
);
  // ****************
  // helpers
  // ****************
  // drive is all zero for one edge after reset, so relations start later
  logic [1:0] up_r;
  logic       up, rd_run, rd_stb, rd_slp, rd_mod, rd_cnf;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) up_r <= 2'h0;
    else if (!up_r[1]) up_r <= up_r + 2'h1;
  end
  assign up = up_r[1];
  assign rd_run = up && reg_rd && reg_addr == 8'h43;
  assign rd_stb = up && reg_rd && reg_addr == 8'h44;
  assign rd_slp = up && reg_rd && reg_addr == 8'h45;
  assign rd_mod = up && reg_rd && reg_addr == 8'h46;
  assign rd_cnf = up && reg_rd && reg_addr == 8'h47;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_CODE: assert property (
    (rd_run && power_state == pstate_normal) || (rd_stb && power_state == pstate_standby) ||
    (rd_slp && power_state == pstate_sleep) |=> drive.voltage_code == reg_rdata[5:0])
    else $error("set point code wrong");
  AST_SLEEP_STATE: assert property (
    rd_mod && power_state == pstate_sleep |=> drive.channel_on == reg_rdata[5] &&
    drive.pfm_forced == reg_rdata[5]) else $error("sleep state wrong");
  AST_MODE: assert property (
    rd_mod |=> drive.switching_mode == reg_rdata[3:0]) else $error("mode wrong");
  AST_CONF: assert property (
    rd_cnf |=> {drive.ramp_select, drive.phase_select, drive.freq_select} == reg_rdata[7:2]
    && drive.low_current_limit == reg_rdata[0]) else $error("configuration wrong");
  AST_FREQ: assert property (
    up && drive.freq_select != 2'h3 |-> drive.freq_khz == (drive.freq_select == 2'h1 ?
    13'h07D0 : drive.freq_select == 2'h2 ? 13'h0FA0 : 13'h03E8)) else $error("rate wrong");
  AST_RANGE_HOLD: assert property (
    up && !cfg_load ##1 !cfg_load |=> $stable(drive.range_high)) else $error("range moved");
  AST_RANGE_LOAD: assert property (
    up && cfg_load |=> ##1 drive.range_high == $past(cfg_range, 2)) else $error("range load");
  AST_RANGE_READ: assert property (
    rd_stb || rd_slp |=> reg_rdata[6] == drive.range_high && !reg_rdata[7])
    else $error("range mirror wrong");
endmodule : buck_cfg_monitor
bind buck_channel_config_regs buck_cfg_monitor u_buck_cfg_monitor (.sys_clk, .nrst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg_load, .cfg_range, .power_state, .drive);
`default_nettype wire

// File: sim/buck_channel_config_regs_tb.sv
// testbench: register traffic for the buck channel bank
`default_nettype none
module buck_channel_config_regs_tb
  import buck_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic             cfg_load = 1'b0, cfg_range = 1'b0, rd_pend = 1'b0, range = 1'b0;
  logic [7:0]       reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0]       exp_q[$];
  logic [31:0]      seed = 32'h06E3;
  power_state_e     power_state = pstate_normal;
  regulator_drive_s drive;
  int               mismatches = 0, check_count = 0, cyc = 0;
  buck_channel_config_regs u_buck_channel_config_regs (.sys_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg_load, .cfg_range, .power_state, .drive);
  initial forever #5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t read %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // no strobe release inside: the next call or an idle call replaces it
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  always @(posedge sys_clk) begin
    if (rd_pend) chk(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    logic [7:0] d [6];
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(8'h43, 8'h00);
    rd(8'h46, 8'h08);
    rd(8'h47, 8'h00);
    rd(8'h48, 8'h00);
    $display("reset values test done");
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      // every frequency code is forced in turn; the rest of each byte is random
      d = '{seed[7:0], seed[13:6], seed[21:14], seed[29:22],
            {seed[31:28], i[1:0], seed[1:0]}, seed[31:24]};
      range = seed[9];
      cfg_load <= 1'b1;
      cfg_range <= range;
      power_state <= power_state_e'(i % 3);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      cfg_load <= 1'b0;
      for (int k = 0; k < 6; k++) bus(1'b1, 1'b0, 8'h43 + 8'(k), d[k]);
      for (int k = 0; k < 6; k++)
        rd(8'h43 + 8'(k), k < 3 ? {1'b0, range, d[k][5:0]} : k == 3 ? d[3] & 8'h2F :
           k == 4 ? d[4] : 8'h00);
    end
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    $display("random traffic test done");
    stop_test();
  end
endmodule : buck_channel_config_regs_tb
`default_nettype wire
